/* File: src/ept_pkg.sv */
// Shared constants and carrier types for the eight-bit period timer.
// Assumes a single 25 MHz core clock and an Avalon-MM register slave.
package ept_pkg;

   // Register word indices on the Avalon-MM slave, taken from byte address bits 4..2, one aligned word each.
   localparam int EPT_ADDR_W = 5;
   localparam logic [2:0] EPT_IDX_TICK = 3'h0;
   localparam logic [2:0] EPT_IDX_CTRL = 3'h1;
   localparam logic [2:0] EPT_IDX_PERIOD = 3'h2;
   localparam logic [2:0] EPT_IDX_STATUS = 3'h3;
   localparam logic [2:0] EPT_IDX_MASK = 3'h4;
   localparam int EPT_IDX_LSB = 2;
   localparam int EPT_IDX_MSB = 4;

   // Reset values of the software-visible registers.
   localparam logic [7:0] EPT_TICK_RST = 8'h00;
   localparam logic [7:0] EPT_PERIOD_RST = 8'hff;
   localparam logic [6:0] EPT_CTRL_RST = 7'h00;

   // Control byte layout: bit 7 unused, 6..3 postscale, 2 run, 1..0 prescale.
   localparam int EPT_CTRL_MSB = 6;
   localparam int EPT_BYTE_MSB = 7;

   // Prescale codes; both codes with the upper bit set divide by sixteen.
   localparam logic [1:0] EPT_PRE_DIV1 = 2'h0;
   localparam logic [1:0] EPT_PRE_DIV4 = 2'h1;
   localparam logic [3:0] EPT_PRE_LIM1 = 4'h0;
   localparam logic [3:0] EPT_PRE_LIM4 = 4'h3;
   localparam logic [3:0] EPT_PRE_LIM16 = 4'hf;

   // Status and mask share one layout: bit 0 is the period match flag.
   localparam int EPT_IRQ_W = 1;

   typedef struct packed {
      logic [3:0] match_postscale_sel;
      logic timer_run;
      logic [1:0] input_prescale_sel;
   } ept_ctrl_t;

   typedef struct packed {
      logic read;
      logic write;
      logic [EPT_ADDR_W-1:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } ept_avs_req_t;

endpackage

/* File: src/ept_prescaler.sv */
// Input prescaler that divides the instruction clock by 1, 4 or 16.
// Assumes the clear input is a one-cycle pulse from register writes.
`timescale 1ns/10ps
module ept_prescaler import ept_pkg::*; (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_run,
   input wire logic i_clear,
   input wire logic [1:0] i_sel,
   output logic o_tick
);

   typedef struct packed {
      logic [3:0] cnt;
   } ept_pre_state_t;

   ept_pre_state_t state_reg;
   ept_pre_state_t state_next;
   logic [3:0] lim;

   // Terminal count for each prescale code.
   function automatic logic [3:0] ept_pre_limit(input logic [1:0] sel);
      if (sel == EPT_PRE_DIV1) begin
         return EPT_PRE_LIM1;
      end else if (sel == EPT_PRE_DIV4) begin
         return EPT_PRE_LIM4;
      end
      return EPT_PRE_LIM16;
   endfunction

   // A clear suppresses the tick so a write never lets a stale count through.
   always_comb begin
      state_next = state_reg;
      lim = ept_pre_limit(i_sel);
      o_tick = i_run && !i_clear && (state_reg.cnt >= lim);
      if (i_clear) begin
         state_next.cnt = '0;
      end else if (i_run) begin
         state_next.cnt = o_tick ? '0 : state_reg.cnt + 4'h1;
      end
   end

   // State register.
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);

   pre_clear_zero_a: assert property (i_clear |=> state_reg.cnt == '0)
      else $error("Prescaler count not cleared.");
   pre_div_four_a: assert property (
      o_tick && i_sel == EPT_PRE_DIV4 |-> $past(state_reg.cnt, 3) == '0 || $past(i_clear))
      else $error("Divide by four tick spacing wrong.");

endmodule

/* File: src/ept_postscaler.sv */
// Four-bit postscaler that turns period matches into flag events.
// Assumes matches arrive as one-cycle pulses on the core clock.
`timescale 1ns/10ps
module ept_postscaler import ept_pkg::*; (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_match,
   input wire logic i_clear,
   input wire logic [3:0] i_sel,
   output logic o_event
);

   typedef struct packed {
      logic [3:0] cnt;
   } ept_post_state_t;

   ept_post_state_t state_reg;
   ept_post_state_t state_next;

   // The event fires on match number sel plus one, then the count restarts.
   always_comb begin
      state_next = state_reg;
      o_event = i_match && !i_clear && (state_reg.cnt >= i_sel);
      if (i_clear) begin
         state_next.cnt = '0;
      end else if (i_match) begin
         state_next.cnt = o_event ? '0 : state_reg.cnt + 4'h1;
      end
   end

   // State register.
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);

   post_event_count_a: assert property (o_event |-> i_match && state_reg.cnt == i_sel)
      else $error("Postscale event at wrong match count.");
   post_clear_zero_a: assert property (i_clear |=> state_reg.cnt == '0)
      else $error("Postscaler count not cleared.");

endmodule

/* File: src/ept_timer.sv */
// Eight-bit period timer with prescaler, postscaler and Avalon-MM registers.
// Assumes one core clock, an asynchronous active-low reset and a bus master
// that holds each request until it sees waitrequest low.
//
// What this block does
// - Counter counts up, wraps to zero after period
// - Period limit resets to all ones
// - Every reset clears the tick counter
// - Postscale field sets matches per flag event
// - Matches advance postscaler; terminal count sets flag
// - Counter write, control write, reset clear scalers
// - Control write keeps the tick counter value
// - Control bit seven always reads zero
// - Unscaled match drives the PWM time base
// - Counter and period readable and writable anytime
`timescale 1ns/10ps
module ept_timer import ept_pkg::*; (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire ept_avs_req_t i_avs,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   output logic o_pwm_timebase,
   output logic o_irq
);

   typedef struct packed {
      logic [7:0] tick;
      ept_ctrl_t ctrl;
      logic [7:0] period;
      logic [EPT_IRQ_W-1:0] status;
      logic [EPT_IRQ_W-1:0] mask;
      logic ack;
      logic [31:0] rdata;
      logic [EPT_IRQ_W-1:0] rd_snap;
      logic match;
   } ept_top_state_t;

   ept_top_state_t state_reg;
   ept_top_state_t state_next;

   logic req;
   logic acc;
   logic [2:0] idx;
   logic lane0;
   logic [7:0] wbyte;
   logic wr_tick;
   logic wr_ctrl;
   logic wr_period;
   logic wr_mask;
   logic rd_status;
   logic scaler_clear;
   logic pre_tick;
   logic inc;
   logic wrap;
   logic post_event;

   // Read value of a register index; unmapped words read as zero.
   function automatic logic [31:0] ept_read_word(input logic [2:0] i,
                                                 input ept_top_state_t s);
      logic [31:0] w;
      w = '0;
      unique case (i)
         EPT_IDX_TICK: begin
            w[EPT_BYTE_MSB:0] = s.tick;
         end
         EPT_IDX_CTRL: begin
            w[EPT_CTRL_MSB:0] = s.ctrl;
         end
         EPT_IDX_PERIOD: begin
            w[EPT_BYTE_MSB:0] = s.period;
         end
         EPT_IDX_STATUS: begin
            w[EPT_IRQ_W-1:0] = s.status;
         end
         EPT_IDX_MASK: begin
            w[EPT_IRQ_W-1:0] = s.mask;
         end
         default: begin
            w = '0;
         end
      endcase
      return w;
   endfunction

   // Bus decode. One wait state: the first cycle of a request only snaps
   // the read data, the second releases waitrequest and commits the access.
   assign req = i_avs.read ^ i_avs.write;
   assign acc = req && state_reg.ack;
   assign idx = i_avs.address[EPT_IDX_MSB:EPT_IDX_LSB];
   assign lane0 = i_avs.byteenable[0];
   assign wbyte = i_avs.writedata[EPT_BYTE_MSB:0];
   assign wr_tick = acc && i_avs.write && lane0 && idx == EPT_IDX_TICK;
   assign wr_ctrl = acc && i_avs.write && lane0 && idx == EPT_IDX_CTRL;
   assign wr_period = acc && i_avs.write && lane0 && idx == EPT_IDX_PERIOD;
   assign wr_mask = acc && i_avs.write && lane0 && idx == EPT_IDX_MASK;
   assign rd_status = acc && i_avs.read && idx == EPT_IDX_STATUS;
   assign o_avs_waitrequest = req && !state_reg.ack;
   assign o_avs_readdata = state_reg.rdata;

   // Writes to the counter or the control byte restart both scalers.
   assign scaler_clear = wr_tick || wr_ctrl;

   ept_prescaler u_pre (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .i_run(state_reg.ctrl.timer_run),
      .i_clear(scaler_clear),
      .i_sel(state_reg.ctrl.input_prescale_sel),
      .o_tick(pre_tick)
   );

   // A counter write takes priority over a coinciding increment.
   assign inc = pre_tick && state_reg.ctrl.timer_run && !wr_tick;
   assign wrap = inc && state_reg.tick == state_reg.period;

   ept_postscaler u_post (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .i_match(wrap),
      .i_clear(scaler_clear),
      .i_sel(state_reg.ctrl.match_postscale_sel),
      .o_event(post_event)
   );

   // Next-state logic for counter, registers, flags and the bus answer.
   always_comb begin
      state_next = state_reg;
      state_next.match = wrap;
      // The acknowledge toggles so back-to-back requests each see a wait.
      state_next.ack = req && !state_reg.ack;
      if (req && !state_reg.ack) begin
         state_next.rdata = i_avs.read ? ept_read_word(idx, state_reg) : '0;
         state_next.rd_snap = (i_avs.read && idx == EPT_IDX_STATUS) ?
                              state_reg.status : '0;
      end
      // Counter: software write wins, else count and wrap at the period.
      if (wr_tick) begin
         state_next.tick = wbyte;
      end else if (wrap) begin
         state_next.tick = EPT_TICK_RST;
      end else if (inc) begin
         state_next.tick = state_reg.tick + 8'h01;
      end
      if (wr_ctrl) begin
         state_next.ctrl = ept_ctrl_t'(wbyte[EPT_CTRL_MSB:0]);
      end
      if (wr_period) begin
         state_next.period = wbyte;
      end
      if (wr_mask) begin
         state_next.mask = wbyte[EPT_IRQ_W-1:0];
      end
      // Only bits that were actually returned are cleared, and a new event
      // in the clearing cycle still sets its bit, so no event is lost.
      if (rd_status) begin
         state_next.status = state_reg.status & ~state_reg.rd_snap;
      end
      if (post_event) begin
         state_next.status[0] = 1'b1;
      end
   end

   // State register; every reset source arrives through i_nrst.
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_reg.tick <= EPT_TICK_RST;
         state_reg.ctrl <= EPT_CTRL_RST;
         state_reg.period <= EPT_PERIOD_RST;
         state_reg.status <= '0;
         state_reg.mask <= '0;
         state_reg.ack <= 1'b0;
         state_reg.rdata <= '0;
         state_reg.rd_snap <= '0;
         state_reg.match <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   // The time base is a registered one-cycle pulse, taken before postscaling.
   assign o_pwm_timebase = state_reg.match;
   assign o_irq = |(state_reg.status & state_reg.mask);

   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);

   // A count step while running below the period adds exactly one.
   sequence count_step_s;
      inc && state_reg.tick != state_reg.period;
   endsequence

   // A request that is held reaches its answer one cycle later.
   sequence held_req_s;
      req && !state_reg.ack ##1 req;
   endsequence

   tick_wrap_zero_a: assert property (wrap |=> state_reg.tick == '0)
      else $error("Counter did not wrap to zero after period match.");
   tick_count_up_a: assert property (
      count_step_s |=> state_reg.tick == $past(state_reg.tick) + 8'h01)
      else $error("Counter did not step by one.");
   ctrl_keeps_tick_a: assert property (
      wr_ctrl |=> state_reg.tick == $past(state_reg.tick))
      else $error("Control write changed the counter.");
   stopped_hold_a: assert property (
      !state_reg.ctrl.timer_run && !wr_tick |=> $stable(state_reg.tick) && !o_pwm_timebase)
      else $error("Stopped timer changed count or made a match.");
   timebase_pulse_a: assert property (
      wrap |=> o_pwm_timebase ##1 !o_pwm_timebase || $past(wrap))
      else $error("Time base pulse misplaced.");
   flag_set_a: assert property (post_event |=> state_reg.status[0])
      else $error("Postscale event did not set the flag.");
   ctrl_bit7_a: assert property (
      held_req_s ##0 i_avs.read && idx == EPT_IDX_CTRL |-> !o_avs_readdata[EPT_BYTE_MSB])
      else $error("Control bit seven read as one.");
   period_rw_a: assert property (
      wr_period |=> state_reg.period == $past(wbyte))
      else $error("Period write not stored.");
   wait_one_a: assert property (
      held_req_s |-> !o_avs_waitrequest)
      else $error("Waitrequest not released after one wait cycle.");
   scaler_restart_a: assert property (
      wr_tick |=> !o_pwm_timebase)
      else $error("Counter write let a match through.");

endmodule

/* File: testbench/ept_pwm_sink.sv */
// Far-side model of a capture/compare/PWM unit that counts period time-base pulses.
// Assumes the time base is a one-cycle pulse in the core clock domain.
`timescale 1ns/10ps
module ept_pwm_sink (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_timebase,
   output logic [7:0] o_pulse_count
);
   // Each pulse starts a new PWM period; the count wraps, so benches compare differences.
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_pulse_count <= 8'h00;
      end else if (i_timebase) begin
         o_pulse_count <= o_pulse_count + 8'h01;
      end
   end
endmodule

/* File: testbench/ept_timer_tb.sv */
// Self-checking bench for the eight-bit period timer.
// Assumes one wait state per bus request and the PWM sink model beside it.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("FAIL %s expected %h seen %h", nm, e, g); end end
module ept_timer_tb import ept_pkg::*;;
   logic i_core_clk = 1'b0;
   logic i_nrst = 1'b0;
   ept_avs_req_t avs = '0;
   logic [31:0] rdata;
   logic [31:0] rv;
   logic avs_wait;
   logic pwm_tb;
   logic irq;
   logic [7:0] pulses;
   int bad_count = 0;
   int n_checks = 0;
   localparam logic [4:0] A_TICK = {EPT_IDX_TICK, 2'b00};
   localparam logic [4:0] A_CTRL = {EPT_IDX_CTRL, 2'b00};
   localparam logic [4:0] A_PER = {EPT_IDX_PERIOD, 2'b00};
   localparam logic [4:0] A_STAT = {EPT_IDX_STATUS, 2'b00};
   localparam logic [4:0] A_MASK = {EPT_IDX_MASK, 2'b00};

   // A 40 ns period gives the 25 MHz core clock.
   always #20 i_core_clk = ~i_core_clk;

   ept_timer uut (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .i_avs(avs),
      .o_avs_readdata(rdata),
      .o_avs_waitrequest(avs_wait),
      .o_pwm_timebase(pwm_tb),
      .o_irq(irq)
   );

   ept_pwm_sink sink (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .i_timebase(pwm_tb),
      .o_pulse_count(pulses)
   );

   // Prints the verdict and ends the run.
   task automatic results();
      if (bad_count == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // One bus transfer; the request stands until waitrequest is sampled low.
   task automatic bus(input logic rd, input logic [4:0] a, input logic [7:0] wd,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge i_core_clk);
      avs.read <= rd;
      avs.write <= !rd;
      avs.address <= a;
      avs.writedata <= {24'h000000, wd};
      avs.byteenable <= 4'hf;
      do begin
         @(posedge i_core_clk);
         n++;
      end while (avs_wait !== 1'b0 && n < 50);
      q = rdata;
      avs.read <= 1'b0;
      avs.write <= 1'b0;
      if (n >= 50) begin
         bad_count++;
      end
   endtask

   // Reset values, the dead control bit, plain read-back and an unmapped place.
   task automatic t_regs();
      bus(1'b1, A_TICK, 8'h00, rv);
      `CHK("tick_reset", 32'h00, rv)
      bus(1'b1, A_PER, 8'h00, rv);
      `CHK("period_reset", 32'hff, rv)
      bus(1'b0, A_CTRL, 8'hff, rv);
      bus(1'b1, A_CTRL, 8'h00, rv);
      `CHK("ctrl_bit7", 32'h7f, rv)
      bus(1'b0, A_CTRL, 8'h00, rv);
      bus(1'b0, A_TICK, 8'ha5, rv);
      bus(1'b1, A_TICK, 8'h00, rv);
      `CHK("tick_rw", 32'ha5, rv)
      bus(1'b0, A_PER, 8'h3c, rv);
      bus(1'b1, A_PER, 8'h00, rv);
      `CHK("period_rw", 32'h3c, rv)
      bus(1'b0, 5'h14, 8'h77, rv);
      bus(1'b1, 5'h14, 8'h00, rv);
      `CHK("unmapped", 32'h00, rv)
   endtask

   // Counts over exactly 64 clocks for every prescale code, then with the timer off.
   task automatic t_prescale();
      logic [7:0] exp_d [5] = '{8'd64, 8'd16, 8'd4, 8'd4, 8'd0};
      logic [31:0] t0;
      bus(1'b0, A_PER, 8'hff, rv);
      for (int i = 0; i < 5; i++) begin
         bus(1'b0, A_TICK, 8'h00, rv);
         bus(1'b0, A_CTRL, (i < 4) ? {6'h01, i[1:0]} : 8'h00, rv);
         bus(1'b1, A_TICK, 8'h00, t0);
         repeat (61) @(posedge i_core_clk);
         bus(1'b1, A_TICK, 8'h00, rv);
         `CHK("tick_rate", exp_d[i], rv[7:0] - t0[7:0])
      end
      bus(1'b0, A_TICK, 8'h5a, rv);
      bus(1'b0, A_CTRL, 8'h01, rv);
      bus(1'b1, A_TICK, 8'h00, rv);
      `CHK("ctrl_keeps_tick", 32'h5a, rv)
   endtask

   // Three matches per flag with period 9; then mask, unmask and read-clear.
   task automatic t_match_irq();
      logic [7:0] p0;
      int n;
      bus(1'b0, A_PER, 8'h09, rv);
      bus(1'b0, A_MASK, 8'h01, rv);
      bus(1'b0, A_TICK, 8'h00, rv);
      p0 = pulses;
      bus(1'b0, A_CTRL, 8'h14, rv);
      n = 0;
      while (irq !== 1'b1 && n < 300) begin
         @(posedge i_core_clk);
         n++;
      end
      // The next match is ten clocks away, so a short settle is safe.
      repeat (3) @(posedge i_core_clk);
      `CHK("matches_per_flag", 8'd3, pulses - p0)
      p0 = pulses;
      repeat (100) @(posedge i_core_clk);
      `CHK("period_pulses", 8'd10, pulses - p0)
      bus(1'b0, A_CTRL, 8'h00, rv);
      `CHK("irq_raised", 1'b1, irq)
      bus(1'b0, A_MASK, 8'h00, rv);
      @(posedge i_core_clk);
      `CHK("irq_masked", 1'b0, irq)
      bus(1'b0, A_MASK, 8'h01, rv);
      @(posedge i_core_clk);
      `CHK("irq_unmasked", 1'b1, irq)
      bus(1'b1, A_STAT, 8'h00, rv);
      `CHK("flag_read", 32'h01, rv)
      @(posedge i_core_clk);
      `CHK("irq_cleared", 1'b0, irq)
      bus(1'b1, A_STAT, 8'h00, rv);
      `CHK("flag_cleared", 32'h00, rv)
      bus(1'b1, A_TICK, 8'h00, rv);
      `CHK("tick_in_range", 1'b1, rv <= 32'h09)
   endtask

   // A second reset while the timer runs restores the counter, period and control registers.
   task automatic t_rereset();
      bus(1'b0, A_CTRL, 8'h04, rv);
      repeat (5) @(posedge i_core_clk);
      i_nrst <= 1'b0;
      repeat (3) @(posedge i_core_clk);
      i_nrst <= 1'b1;
      bus(1'b1, A_TICK, 8'h00, rv);
      `CHK("tick_rereset", 32'h00, rv)
      bus(1'b1, A_PER, 8'h00, rv);
      `CHK("period_rereset", 32'hff, rv)
      bus(1'b1, A_CTRL, 8'h00, rv);
      `CHK("ctrl_rereset", 32'h00, rv)
   endtask

   // Main sequence after a 20-cycle reset.
   initial begin
      repeat (20) @(posedge i_core_clk);
      i_nrst <= 1'b1;
      t_regs();
      t_prescale();
      t_match_irq();
      t_rereset();
      results();
   end

   // Watchdog well beyond the six hundred or so cycles the tests need.
   initial begin
      repeat (5000) @(posedge i_core_clk);
      bad_count++;
      results();
   end
endmodule
